// file: hw/bsp_clkgen_spi.sv
// Purpose: Sample-rate generator and clock-stop SPI framing for a buffered serial port
// Assumes: Pins and the external sample clock are asynchronous; config ports are static
// Notes:   Notes on behaviour below
`timescale 1ns/1ps
`default_nettype none
module bsp_clkgen_spi (
    input  wire logic                        CLK_I,
    input  wire logic                        SRST_I,
    input  wire logic                        SRG_SOURCE_SELECT_I,
    input  wire logic [bsp_pkg::DIV_W-1:0]   CLOCK_DIVIDE_VALUE_I,
    input  wire logic [1:0]                  CLOCK_STOP_FIELD_I,
    input  wire logic                        SPI_MASTER_I,
    input  wire logic                        TX_CLOCK_POLARITY_I,
    input  wire logic                        RX_CLOCK_POLARITY_I,
    input  wire logic                        TX_FSYNC_POLARITY_I,
    input  wire logic                        RX_FSYNC_POLARITY_I,
    input  wire logic                        TX_CLOCK_DIRECTION_I,
    input  wire logic                        RX_CLOCK_DIRECTION_I,
    input  wire logic                        TX_FSYNC_DIRECTION_I,
    input  wire logic                        RX_FSYNC_DIRECTION_I,
    input  wire logic                        FRAME_START_I,
    input  wire logic [bsp_pkg::BITS_W-1:0]  XFER_BITS_I,
    input  wire logic                        EXT_SAMPLE_CLK_I,
    input  wire logic                        TX_BIT_CLOCK_I,
    output logic                             TX_BIT_CLOCK_O,
    output logic                             TX_BIT_CLOCK_OE_O,
    input  wire logic                        TX_FRAME_SYNC_I,
    output logic                             TX_FRAME_SYNC_O,
    output logic                             TX_FRAME_SYNC_OE_O,
    input  wire logic                        RX_BIT_CLOCK_I,
    output logic                             RX_BIT_CLOCK_O,
    output logic                             RX_BIT_CLOCK_OE_O,
    input  wire logic                        RX_FRAME_SYNC_I,
    output logic                             RX_FRAME_SYNC_O,
    output logic                             RX_FRAME_SYNC_OE_O,
    output logic                             SRG_OUTPUT_CLOCK_O,
    output logic                             SRG_RISE_O,
    output logic                             INT_TX_CLK_O,
    output logic                             INT_RX_CLK_O,
    output logic                             INT_TX_FS_O,
    output logic                             INT_RX_FS_O,
    output logic                             SPI_ACTIVE_O,
    output logic                             BUSY_O,
    output logic                             DONE_O
);
    typedef struct packed {
        logic [bsp_pkg::NSYNC-1:0]  meta;
        logic [bsp_pkg::NSYNC-1:0]  sync;
        logic                       ext_prev;
        logic [bsp_pkg::LEN_W-1:0]  cnt;
        logic                       srg_output_clock;
        logic                       rise;
        bsp_pkg::bsp_state_e        state;
        logic [bsp_pkg::BITS_W-1:0] bitcnt;
        logic                       done;
        logic                       spi;
        logic [3:0]                 oe;
        logic [3:0]                 pin;
        logic [3:0]                 intl;
    } bsp_regs_s;

    bsp_regs_s q;
    bsp_regs_s d;

    logic                      spi_mode;
    logic                      slave;
    logic                      eff_src;
    logic [bsp_pkg::DIV_W-1:0] eff_div;
    logic                      in_tick;
    logic                      toggle;
    logic [bsp_pkg::LEN_W-1:0] len_hi;
    logic [bsp_pkg::LEN_W-1:0] len_lo;
    logic                      fs_act;
    logic                      txfs_pol;
    logic                      rxfs_pol;

    // Phase length in input ticks; a zero divide is clamped to one tick per phase
    function automatic logic [bsp_pkg::LEN_W-1:0] phase_len(
        input logic [bsp_pkg::DIV_W-1:0] dv,
        input logic                      hi
    );
        logic [bsp_pkg::LEN_W-1:0] half;
        half = ({1'b0, dv} + bsp_pkg::LEN_ONE) >> 1;
        if (!dv[0] && (dv != bsp_pkg::DIV_RST)) begin
            phase_len = hi ? ({1'b0, dv} >> 1) + bsp_pkg::LEN_ONE : ({1'b0, dv} >> 1);
        end else begin
            phase_len = (half == '0) ? bsp_pkg::LEN_ONE : half;
        end
    endfunction : phase_len

    always_comb begin
        spi_mode = CLOCK_STOP_FIELD_I[bsp_pkg::CLKSTOP_SPI_BIT];
        slave    = spi_mode && !SPI_MASTER_I;
        eff_src  = slave ? bsp_pkg::SRC_CPU : SRG_SOURCE_SELECT_I;
        eff_div  = slave ? bsp_pkg::SLAVE_DIV : CLOCK_DIVIDE_VALUE_I;
        txfs_pol = spi_mode ? 1'b1 : TX_FSYNC_POLARITY_I;
        rxfs_pol = spi_mode ? 1'b1 : RX_FSYNC_POLARITY_I;
        len_hi   = phase_len(eff_div, 1'b1);
        len_lo   = phase_len(eff_div, 1'b0);
        d        = q;
        d.meta   = {RX_FRAME_SYNC_I, RX_BIT_CLOCK_I, TX_FRAME_SYNC_I, TX_BIT_CLOCK_I,
                    EXT_SAMPLE_CLK_I};
        d.sync   = q.meta;
        d.ext_prev = q.sync[bsp_pkg::SY_EXT];
        in_tick  = eff_src || (q.sync[bsp_pkg::SY_EXT] && !q.ext_prev);
        toggle   = in_tick && (q.cnt == '0);
        if (in_tick) begin
            if (toggle) begin
                d.srg_output_clock = !q.srg_output_clock;
                d.cnt  = (q.srg_output_clock ? len_lo : len_hi) - bsp_pkg::LEN_ONE;
            end else begin
                d.cnt  = q.cnt - bsp_pkg::LEN_ONE;
            end
        end
        d.rise = toggle && !q.srg_output_clock;
        d.done = 1'b0;
        unique case (q.state)
            bsp_pkg::ST_IDLE: begin
                if (FRAME_START_I && (spi_mode ? SPI_MASTER_I : TX_FSYNC_DIRECTION_I)) begin
                    d.state = bsp_pkg::ST_SETUP;
                end
            end
            bsp_pkg::ST_SETUP: begin
                if (d.rise) begin
                    d.state  = spi_mode ? bsp_pkg::ST_RUN : bsp_pkg::ST_IDLE;
                    d.bitcnt = '0;
                    d.done   = !spi_mode;
                end
            end
            bsp_pkg::ST_RUN: begin
                if (d.rise) begin
                    if (q.bitcnt == XFER_BITS_I) begin
                        d.state = bsp_pkg::ST_HOLD;
                    end else begin
                        d.bitcnt = q.bitcnt + bsp_pkg::BITS_ONE;
                    end
                end
            end
            bsp_pkg::ST_HOLD: begin
                if (toggle && q.srg_output_clock) begin
                    d.state = bsp_pkg::ST_IDLE;
                    d.done  = 1'b1;
                end
            end
        endcase
        fs_act = (d.state != bsp_pkg::ST_IDLE);
        d.spi  = spi_mode;
        // pin directions; oe order is rxfs, rxclk, txfs, txclk
        if (spi_mode) begin
            d.oe = SPI_MASTER_I ? 4'h3 : 4'h0;
        end else begin
            d.oe = {RX_FSYNC_DIRECTION_I, RX_CLOCK_DIRECTION_I,
                    TX_FSYNC_DIRECTION_I, TX_CLOCK_DIRECTION_I};
        end
        // polarity on driven pins; SPI clock stops outside a transfer
        d.pin[0] = ((spi_mode ? (d.state == bsp_pkg::ST_RUN) && d.srg_output_clock : d.srg_output_clock))
                   ^ TX_CLOCK_POLARITY_I;
        d.pin[1] = fs_act ^ txfs_pol;
        d.pin[2] = d.srg_output_clock ^ RX_CLOCK_POLARITY_I;
        d.pin[3] = fs_act ^ rxfs_pol;
        d.intl[0] = d.oe[0] ? d.pin[0] ^ TX_CLOCK_POLARITY_I
                            : q.sync[bsp_pkg::SY_TXCLK] ^ TX_CLOCK_POLARITY_I;
        d.intl[1] = d.oe[1] ? fs_act : q.sync[bsp_pkg::SY_TXFS] ^ txfs_pol;
        d.intl[2] = d.oe[2] ? d.srg_output_clock : q.sync[bsp_pkg::SY_RXCLK] ^ RX_CLOCK_POLARITY_I;
        d.intl[3] = d.oe[3] ? fs_act : q.sync[bsp_pkg::SY_RXFS] ^ rxfs_pol;
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            q       <= '0;
            q.state <= bsp_pkg::ST_IDLE;
        end else begin
            q <= d;
        end
    end

    assign TX_BIT_CLOCK_O     = q.pin[0];
    assign TX_FRAME_SYNC_O    = q.pin[1];
    assign RX_BIT_CLOCK_O     = q.pin[2];
    assign RX_FRAME_SYNC_O    = q.pin[3];
    assign TX_BIT_CLOCK_OE_O  = q.oe[0];
    assign TX_FRAME_SYNC_OE_O = q.oe[1];
    assign RX_BIT_CLOCK_OE_O  = q.oe[2];
    assign RX_FRAME_SYNC_OE_O = q.oe[3];
    assign INT_TX_CLK_O       = q.intl[0];
    assign INT_TX_FS_O        = q.intl[1];
    assign INT_RX_CLK_O       = q.intl[2];
    assign INT_RX_FS_O        = q.intl[3];
    assign SRG_OUTPUT_CLOCK_O = q.srg_output_clock;
    assign SRG_RISE_O         = q.rise;
    assign SPI_ACTIVE_O       = q.spi;
    assign BUSY_O             = (q.state != bsp_pkg::ST_IDLE);
    assign DONE_O             = q.done;

    // Checking helpers: ticks seen in the current phase, and whether the
    // divide setting held steady since the phase began
    logic [bsp_pkg::LEN_W-1:0] ph_cnt;
    logic                      ph_ok;
    logic [bsp_pkg::DIV_W-1:0] ph_div;
    logic [bsp_pkg::LEN_W:0]   per_cnt;
    logic                      per_ok;
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ph_cnt  <= '0;
            ph_ok   <= 1'b0;
            ph_div  <= bsp_pkg::DIV_RST;
            per_cnt <= '0;
            per_ok  <= 1'b0;
        end else begin
            if (toggle) begin
                ph_cnt <= '0;
                ph_ok  <= 1'b1;
                ph_div <= eff_div;
            end else if (in_tick) begin
                ph_cnt <= ph_cnt + bsp_pkg::LEN_ONE;
            end
            if (eff_div != ph_div) begin
                ph_ok <= 1'b0;
            end
            if (toggle && !q.srg_output_clock) begin
                per_cnt <= '0;
                per_ok  <= ph_ok && (eff_div == ph_div);
            end else if (in_tick) begin
                per_cnt <= per_cnt + 10'h001;
            end
        end
    end

    AST_PERIOD: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (toggle && !q.srg_output_clock && per_ok && ph_ok && eff_div == ph_div && eff_div != '0)
        |-> (per_cnt + 10'h001 == {2'h0, eff_div} + 10'h001))
        else $error("bit clock period differs from divide plus one");
    AST_HIGH_EVEN: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (toggle && q.srg_output_clock && ph_ok && eff_div == ph_div && !eff_div[0] && eff_div != '0)
        |-> (ph_cnt + bsp_pkg::LEN_ONE == ({1'b0, eff_div} >> 1) + bsp_pkg::LEN_ONE))
        else $error("even divide high phase length wrong");
    AST_LOW_EVEN: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (toggle && !q.srg_output_clock && ph_ok && eff_div == ph_div && !eff_div[0] && eff_div != '0)
        |-> (ph_cnt + bsp_pkg::LEN_ONE == ({1'b0, eff_div} >> 1)))
        else $error("even divide low phase length wrong");
    AST_ODD_PHASE: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (toggle && ph_ok && eff_div == ph_div && eff_div[0])
        |-> (ph_cnt + bsp_pkg::LEN_ONE == ({1'b0, eff_div} + bsp_pkg::LEN_ONE) >> 1))
        else $error("odd divide phase length wrong");
    AST_CPU_SOURCE: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (SRG_SOURCE_SELECT_I && q.cnt != '0) |=> (q.cnt == $past(q.cnt) - bsp_pkg::LEN_ONE))
        else $error("generator did not count on the CPU clock");
    AST_SLAVE_HALF: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (slave && q.cnt == '0) [*3] |-> (q.srg_output_clock != $past(q.srg_output_clock)))
        else $error("slave generator is not half the CPU clock");
    AST_SPI_SEEN: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (CLOCK_STOP_FIELD_I == bsp_pkg::CLKSTOP_SPI_NODLY ||
         CLOCK_STOP_FIELD_I == bsp_pkg::CLKSTOP_SPI_DLY) |=> SPI_ACTIVE_O)
        else $error("SPI mode not entered");
    AST_MASTER_DIR: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (spi_mode && SPI_MASTER_I) |=> (TX_BIT_CLOCK_OE_O && TX_FRAME_SYNC_OE_O &&
                                        !RX_BIT_CLOCK_OE_O && !RX_FRAME_SYNC_OE_O))
        else $error("SPI master pin directions wrong");
    AST_SLAVE_DIR: assert property (@(posedge CLK_I) disable iff (SRST_I)
        slave |=> !(TX_BIT_CLOCK_OE_O || TX_FRAME_SYNC_OE_O ||
                    RX_BIT_CLOCK_OE_O || RX_FRAME_SYNC_OE_O))
        else $error("SPI slave drives a pin");
    AST_SELECT_LOW: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (spi_mode && SPI_MASTER_I && q.state == bsp_pkg::ST_SETUP) |=> !TX_FRAME_SYNC_O)
        else $error("slave select not driven low");
    AST_SETUP_EDGE: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (q.state == bsp_pkg::ST_SETUP ##1 q.state == bsp_pkg::ST_RUN)
        |-> ($rose(q.srg_output_clock) && !TX_FRAME_SYNC_O))
        else $error("transfer did not begin on a rising edge");
    AST_SLAVE_FS: assert property (@(posedge CLK_I) disable iff (SRST_I)
        slave |=> (INT_TX_FS_O == !$past(q.sync[bsp_pkg::SY_TXFS])))
        else $error("slave select not inverted internally");
    AST_CLK_POL: assert property (@(posedge CLK_I) disable iff (SRST_I)
        (!spi_mode && TX_CLOCK_DIRECTION_I) |=>
        (TX_BIT_CLOCK_O == (q.srg_output_clock ^ $past(TX_CLOCK_POLARITY_I))))
        else $error("transmit clock polarity not applied");
endmodule : bsp_clkgen_spi
`default_nettype wire

// file: hw/bsp_pkg.sv
// Purpose: Shared constants for the serial port clock generator and clock-stop SPI block
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes:   Widths fixed; the divide field width is a plain choice
package bsp_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned DIV_W         = 8;
    localparam int unsigned LEN_W         = DIV_W + 1;
    localparam int unsigned BITS_W        = 6;
    localparam int unsigned NSYNC         = 5;
    // Synchroniser lanes
    localparam int unsigned SY_EXT   = 0;
    localparam int unsigned SY_TXCLK = 1;
    localparam int unsigned SY_TXFS  = 2;
    localparam int unsigned SY_RXCLK = 3;
    localparam int unsigned SY_RXFS  = 4;
    // Clock-stop field codes that select SPI operation
    localparam logic [1:0] CLKSTOP_SPI_NODLY = 2'h2;
    localparam logic [1:0] CLKSTOP_SPI_DLY   = 2'h3;
    localparam int unsigned CLKSTOP_SPI_BIT  = 1;
    // Forced slave-mode generator setting: CPU source, divide value one, so half the CPU clock
    localparam logic             SRC_CPU       = 1'b1;
    localparam logic [DIV_W-1:0] SLAVE_DIV     = 8'h01;
    localparam logic [LEN_W-1:0] LEN_ONE       = 9'h001;
    localparam logic [DIV_W-1:0] DIV_RST       = 8'h00;
    localparam logic [BITS_W-1:0] BITS_ONE     = 6'h01;
    // Transfer sequence, Gray coded along idle-setup-run-hold
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_SETUP = 2'h1,
        ST_RUN   = 2'h3,
        ST_HOLD  = 2'h2
    } bsp_state_e;
endpackage : bsp_pkg

// file: test/bsp_peer_model.sv
// Purpose: Far-side peer, acting as sample clock source and as SPI master stand-in
// Assumes: Own timing, unrelated to the block clock
// Notes:   Released pins fall to the bench pull-ups
`timescale 1ns/1ps
`default_nettype none
module bsp_peer_model #(
    parameter int unsigned HALF_NS = 40
) (
    output logic ext_clk_o,
    output logic en_o,
    output logic sclk_o,
    output logic sel_n_o
);
    // Offset keeps sample clock edges clear of block clock edges
    initial begin
        ext_clk_o = 1'b0;
        en_o = 1'b0;
        sclk_o = 1'b1;
        sel_n_o = 1'b1;
        #3;
        forever #(HALF_NS) ext_clk_o = ~ext_clk_o;
    end
    task automatic hold(input logic en, input logic lvl);
        en_o = en;
        sclk_o = lvl;
        sel_n_o = lvl;
    endtask : hold
    // Select falls with the clock, half a period before its first rise; clock stands still between frames
    task automatic frame(input int nbits);
        hold(1'b1, 1'b0);
        repeat (nbits) begin
            #(HALF_NS) sclk_o = 1'b1;
            #(HALF_NS) sclk_o = 1'b0;
        end
        #(HALF_NS) sel_n_o = 1'b1;
        #(HALF_NS) en_o = 1'b0;
    endtask : frame
endmodule : bsp_peer_model
`default_nettype wire

// file: test/buffered_serial_port_clocking_spi_tb.sv
// Purpose: Self-checking bench for the generator and clock-stop SPI block
// Assumes: Released pins sit at a pull-up level
// Notes:   Drivers queue expected results; monitors pop and compare
`timescale 1ns/1ps
`default_nettype none
module buffered_serial_port_clocking_spi_tb;
    typedef struct {int hi; int lo;} bsp_phase_s;
    logic       clk, srst, src, master, fst, tcp, rcp, tfp, rfp, tcd, rcd, tfd, rfd;
    logic [7:0] div;
    logic [1:0] cs;
    logic [5:0] bits;
    logic       ext, p_en, p_lv, p_sel, tc, tc_oe, tf, tf_oe, rc, rc_oe, rf, rf_oe;
    logic       srg, rise, itc, irc, itf, irf, act, busy, done;
    wire        tc_w, tf_w, rc_w, rf_w;
    int         err_count, check_count;
    bsp_phase_s ph_q[$];
    int         xq[$];
    assign tc_w = tc_oe ? tc : (p_en ? p_lv : 1'b1);
    assign tf_w = tf_oe ? tf : (p_en ? p_sel : 1'b1);
    assign rc_w = rc_oe ? rc : (p_en ? p_lv : 1'b1);
    assign rf_w = rf_oe ? rf : (p_en ? p_sel : 1'b1);
    bsp_peer_model i_peer (.ext_clk_o(ext), .en_o(p_en), .sclk_o(p_lv), .sel_n_o(p_sel));
    bsp_clkgen_spi i_dut (
        .CLK_I(clk), .SRST_I(srst), .SRG_SOURCE_SELECT_I(src), .CLOCK_DIVIDE_VALUE_I(div),
        .CLOCK_STOP_FIELD_I(cs), .SPI_MASTER_I(master), .TX_CLOCK_POLARITY_I(tcp),
        .RX_CLOCK_POLARITY_I(rcp), .TX_FSYNC_POLARITY_I(tfp), .RX_FSYNC_POLARITY_I(rfp),
        .TX_CLOCK_DIRECTION_I(tcd), .RX_CLOCK_DIRECTION_I(rcd), .TX_FSYNC_DIRECTION_I(tfd),
        .RX_FSYNC_DIRECTION_I(rfd), .FRAME_START_I(fst), .XFER_BITS_I(bits),
        .EXT_SAMPLE_CLK_I(ext), .TX_BIT_CLOCK_I(tc_w), .TX_BIT_CLOCK_O(tc),
        .TX_BIT_CLOCK_OE_O(tc_oe), .TX_FRAME_SYNC_I(tf_w), .TX_FRAME_SYNC_O(tf),
        .TX_FRAME_SYNC_OE_O(tf_oe), .RX_BIT_CLOCK_I(rc_w), .RX_BIT_CLOCK_O(rc),
        .RX_BIT_CLOCK_OE_O(rc_oe), .RX_FRAME_SYNC_I(rf_w), .RX_FRAME_SYNC_O(rf),
        .RX_FRAME_SYNC_OE_O(rf_oe), .SRG_OUTPUT_CLOCK_O(srg), .SRG_RISE_O(rise),
        .INT_TX_CLK_O(itc), .INT_RX_CLK_O(irc), .INT_TX_FS_O(itf), .INT_RX_FS_O(irf),
        .SPI_ACTIVE_O(act), .BUSY_O(busy), .DONE_O(done));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic tick();
        @(posedge clk);
        #2;
    endtask : tick
    task automatic chk(input bit ok, input string msg);
        check_count++;
        if (!ok) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic push_wait(input bsp_phase_s e);
        ph_q.push_back(e);
        for (int t = 0; t < 3000 && ph_q.size() != 0; t++) tick();
        chk(ph_q.size() == 0, "phase timeout");
    endtask : push_wait
    // Zero divide is clamped to one tick per phase
    task automatic gen_case(input logic s, input int d, input int k);
        src = s;
        div = 8'(d);
        {tcd, rcd, tfd, rfd, tfp} = 5'($urandom);
        repeat (300) tick();
        if (d == 0) push_wait('{k, k});
        else if (d % 2 == 0) push_wait('{(d / 2 + 1) * k, d / 2 * k});
        else push_wait('{(d + 1) / 2 * k, (d + 1) / 2 * k});
    endtask : gen_case
    task automatic spi_master(input logic [1:0] c, input logic p, input int d, input int n);
        {cs, tcp, master, src, div, bits} = {c, p, 2'b11, 8'(d), 6'(n)};
        repeat (300) tick();
        chk(act === 1'b1 && tc === p, "spi idle");
        xq.push_back(n + 1);
        fst = 1'b1;
        tick();
        fst = 1'b0;
        tick();
        chk(busy === 1'b1 && tf === 1'b0, "select");
        chk({tc_oe, tf_oe, rc_oe, rf_oe} === 4'hc, "master dirs");
        // Start while busy must be ignored
        fst = 1'b1;
        tick();
        fst = 1'b0;
        for (int t = 0; t < 3000 && done !== 1'b1; t++) tick();
        chk(done === 1'b1 && busy === 1'b0 && tf === 1'b1 && tc === p, "end");
    endtask : spi_master
    initial begin : phase_mon
        bsp_phase_s e;
        int         h;
        int         l;
        forever begin
            wait (ph_q.size() != 0);
            @(posedge srg);
            h = 0;
            l = 0;
            while (srg === 1'b1) begin
                @(posedge clk);
                #1 h++;
            end
            while (srg === 1'b0) begin
                @(posedge clk);
                #1 l++;
            end
            e = ph_q.pop_front();
            chk(h == e.hi && l == e.lo, "phase");
        end
    end
    initial begin : edge_mon
        logic pc;
        logic ps;
        int   n;
        pc = 1'b0;
        ps = 1'b0;
        n = 0;
        forever begin
            @(posedge clk);
            #1 if (busy === 1'b1 && tc !== pc && tc !== tcp) begin
                n++;
                chk(tf === 1'b0, "select late");
            end
            pc = tc;
            // Rise pulse coincides with the first cycle of a high phase
            chk(rise === (srg & ~ps), "rise pulse");
            chk(rc === (srg ^ rcp), "rx clock out");
            chk(rf === (busy ^ (act | rfp)), "rx sync out");
            ps = srg;
            if (done === 1'b1 && xq.size() != 0) begin
                chk(n == xq.pop_front(), "edges");
                n = 0;
            end
        end
    end
    initial begin : watchdog
        repeat (60000) @(posedge clk);
        err_count++;
        complete_run();
    end
    initial begin : main
        void'($urandom(37));
        {srst, src, master, fst, tcp, rcp, tfp, rfp, tcd, rcd, tfd, rfd} = 12'h800;
        {div, cs, bits} = 16'h0000;
        repeat (16) @(posedge clk);
        #2 chk({srg, busy, done, tc_oe, tf_oe} === 5'h00, "reset");
        srst = 1'b0;
        for (int i = 0; i < 5; i++) gen_case(1'b1, i, 1);
        repeat (3) gen_case(1'b1, $urandom % 32, 1);
        gen_case(1'b0, 2, 8);
        gen_case(1'b1, 254, 1);
        // Plain frame: sync stands until the next generator rise, so no rising clock edge in it
        {cs, tfd, tfp} = 4'h3;
        xq.push_back(0);
        fst = 1'b1;
        tick();
        chk(busy === 1'b1 && tf === 1'b0, "plain sync");
        fst = 1'b0;
        for (int t = 0; t < 3000 && done !== 1'b1; t++) tick();
        chk(done === 1'b1 && busy === 1'b0 && tf === 1'b1, "plain frame");
        {tcd, rcd, tfd, rfd} = 4'h0;
        for (int i = 0; i < 4; i++) begin
            {tcp, rcp, tfp, rfp} = {4{i[1]}};
            i_peer.hold(1'b1, i[0]);
            repeat (8) tick();
            chk({itc, irc, itf, irf} === {4{i[0] ^ i[1]}}, "polarity");
        end
        i_peer.hold(1'b0, 1'b1);
        for (int v = 0; v < 4; v++)
            spi_master({1'b1, v[1]}, v[0], $urandom % 6, v == 0 ? 0 : 63 - v);
        {cs, master, src, div} = {2'h3, 2'b00, 8'h07};
        repeat (300) tick();
        chk({tc_oe, tf_oe, rc_oe, rf_oe} === 4'h0, "slave dirs");
        push_wait('{1, 1});
        fork
            i_peer.frame(5);
            begin
                repeat (12) tick();
                chk(itf === 1'b1 && irf === 1'b1, "select in");
            end
        join
        repeat (8) tick();
        chk(itf === 1'b0 && irf === 1'b0, "select out");
        chk(ph_q.size() == 0 && xq.size() == 0, "pending");
        complete_run();
    end
endmodule : buffered_serial_port_clocking_spi_tb
`default_nettype wire
